//--- dpt_pkg.sv
// shared constants and types of the drive protection trip logic
// assumes a single 25 MHz control clock and an active-low asynchronous reset
package dpt_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int LOSS_TICK_NS  = 100_000_000;             // 0.1 s step of detect time
	localparam int LOSS_TICK_CYC = LOSS_TICK_NS / CLK_PERIOD_NS;
	localparam int OL_TICK_NS    = 1_000_000;               // 1 ms overload integration step
	localparam int OL_TICK_CYC   = OL_TICK_NS / CLK_PERIOD_NS;

	// ************************************************************
	// configuration selectors and codes
	// ************************************************************
	localparam logic [3:0] CFG_OPEN_PHASE = 4'h0;
	localparam logic [3:0] CFG_IN1_FUNC   = 4'h1;           // inputs 1..5 at 1..5
	localparam logic [3:0] CFG_RELAY_FUNC = 4'h6;
	localparam logic [3:0] CFG_OUT2_FUNC  = 4'h7;
	localparam logic [3:0] CFG_LOSS_CRIT  = 4'h8;
	localparam logic [3:0] CFG_LOSS_ACT   = 4'h9;
	localparam logic [3:0] CFG_LOSS_TIME  = 4'ha;

	localparam int         NUM_INPUTS     = 5;
	localparam int         STD_INPUTS     = 3;
	localparam logic [4:0] IN_FUNC_MAX    = 5'h1b;          // 27
	localparam logic [4:0] IN_FUNC_NO_TRIP = 5'h12;         // 18
	localparam logic [4:0] IN_FUNC_NC_TRIP = 5'h13;         // 19
	localparam logic [4:0] IN1_FUNC_RST   = 5'h00;
	localparam logic [4:0] IN2_FUNC_RST   = 5'h01;
	localparam logic [4:0] IN3_FUNC_RST   = 5'h02;
	localparam logic [4:0] IN4_FUNC_RST   = 5'h03;
	localparam logic [4:0] IN5_FUNC_RST   = 5'h04;

	localparam logic [4:0] OUT_FUNC_MAX   = 5'h13;          // 19
	localparam logic [4:0] OUT_FUNC_RST   = 5'h11;          // 17
	localparam logic [4:0] OUT_FUNC_OL    = 5'h06;
	localparam logic [4:0] OUT_FUNC_LOSS  = 5'h0b;

	localparam logic [1:0] CRIT_MAX       = 2'h2;
	localparam logic [1:0] CRIT_HALF      = 2'h1;
	localparam logic [1:0] CRIT_FULL      = 2'h2;
	localparam logic [1:0] ACT_MAX        = 2'h2;
	localparam logic [1:0] ACT_HOLD       = 2'h0;
	localparam logic [1:0] ACT_FREE_RUN   = 2'h1;
	localparam logic [1:0] ACT_DECEL      = 2'h2;
	localparam logic [10:0] LOSS_TIME_MIN = 11'h001;        // 0.1 s
	localparam logic [10:0] LOSS_TIME_MAX = 11'h4b0;        // 120.0 s
	localparam logic [10:0] LOSS_TIME_RST = 11'h00a;        // 1.0 s

	// speed reference source
	localparam logic [1:0] REF_MAIN_V     = 2'h1;
	localparam logic [1:0] REF_ALT_V_AUX_I = 2'h2;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic [3:0]  sel;
		logic [11:0] data;
	} dpt_cfg_t;

	typedef struct packed {
		logic open_phase;
		logic ext_no;
		logic ext_nc;
		logic overload;
		logic cmd_loss;
	} dpt_trip_t;

endpackage

//--- dpt_overload.sv
// inverse-time overload integrator
// assumes current samples and rated current in the same units, synchronous to clk
`timescale 1ns/1ps
module dpt_overload #(
	parameter int         CUR_W    = 12,
	parameter int         ACC_W    = 24,
	parameter int         TICK_CYC = dpt_pkg::OL_TICK_CYC,
	parameter logic [23:0] LIMIT   = 24'h0186a0
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [CUR_W-1:0] input_current,
	input  wire logic [CUR_W-1:0] rated_current,
	output logic                  overload_r
);
	import dpt_pkg::*;

	logic [31:0]      tick_cnt_r;
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic             tick;
	logic             over;
	logic [CUR_W-1:0] excess;

	// refuse sizes the fixed-width limit compare cannot serve
	if (ACC_W != 24 || CUR_W >= ACC_W || TICK_CYC < 1) begin : g_bad_param
		$error("dpt_overload: unsupported parameters");
	end

	// excess above rating adds each tick, so a larger excess trips sooner
	assign tick   = (tick_cnt_r == 32'(TICK_CYC - 1));
	assign over   = (input_current > rated_current);
	assign excess = input_current - rated_current;
	assign acc_nxt = !tick ? acc_r :
		over ? ((acc_r + ACC_W'(excess) < acc_r) ? {ACC_W{1'b1}} : acc_r + ACC_W'(excess)) :
		(acc_r != '0) ? acc_r - ACC_W'(1) : acc_r;

	// tick divider and integrator
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_r <= 32'h0;
			acc_r      <= '0;
			overload_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
			acc_r      <= acc_nxt;
			overload_r <= (acc_nxt >= LIMIT);
		end
	end

	AST_OL_INVERSE: assert property (@(posedge clk) disable iff (!reset_n)
		tick && over && acc_r >= LIMIT |=> overload_r)
		else $error("overload not flagged above limit");

endmodule

//--- dpt_trip_logic.sv
// protection and trip logic: open phase, external trips, overload, command loss
// assumes all pins and configuration writes are synchronous to clk
`timescale 1ns/1ps
module dpt_trip_logic #(
	parameter int LOSS_TICK = dpt_pkg::LOSS_TICK_CYC,
	parameter int OL_TICK   = dpt_pkg::OL_TICK_CYC,
	parameter int AN_W      = 10,
	parameter int CUR_W     = 12
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 cfg_wr,
	input  wire dpt_pkg::dpt_cfg_t    cfg,
	input  wire logic                 advanced_io,
	input  wire logic [2:0]           phase_open,
	input  wire logic [4:0]           input_terminal,
	input  wire logic [CUR_W-1:0]     input_current,
	input  wire logic [CUR_W-1:0]     inverter_rated_current,
	input  wire logic [1:0]           speed_ref_source,
	input  wire logic [AN_W-1:0]      main_voltage_input,
	input  wire logic [AN_W-1:0]      alt_voltage_input,
	input  wire logic [AN_W-1:0]      aux_current_input,
	input  wire logic [AN_W-1:0]      main_voltage_loss_threshold,
	input  wire logic [AN_W-1:0]      alt_voltage_loss_threshold,
	input  wire logic [AN_W-1:0]      aux_current_loss_threshold,
	input  wire logic                 clear_req,
	output dpt_pkg::dpt_trip_t        trip_status_r,
	output logic                      output_block_r,
	output logic                      decel_stop_r,
	output logic                      hold_speed_r,
	output logic                      trip_relay_r,
	output logic                      output2_r
);
	import dpt_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************
	// analog input below threshold under the selected criterion
	function automatic logic below(input logic [AN_W-1:0] x, input logic [AN_W-1:0] thr,
		input logic [1:0] crit);
		case (crit)
			CRIT_HALF: below = (x < (thr >> 1));
			CRIT_FULL: below = (x < thr);
			default:   below = 1'b0;
		endcase
	endfunction

	// output terminal drive for a function code
	function automatic logic out_drive(input logic [4:0] func, input dpt_trip_t t);
		case (func)
			OUT_FUNC_OL:   out_drive = t.overload;
			OUT_FUNC_LOSS: out_drive = t.cmd_loss;
			default:       out_drive = 1'b0;
		endcase
	endfunction

	// elaboration-time refusal of sizes the logic cannot serve
	if (AN_W < 2 || CUR_W < 2 || CUR_W > 23 || LOSS_TICK < 1 || OL_TICK < 1) begin : g_bad_param
		$error("dpt_trip_logic: unsupported parameters");
	end

	// ************************************************************
	// configuration store
	// ************************************************************
	logic        open_phase_guard_select;
	logic [4:0]  in_func_r [NUM_INPUTS];
	logic [4:0]  relay_function_select;
	logic [4:0]  output2_function_select;
	logic [1:0]  loss_criterion_select;
	logic [1:0]  loss_action_select;
	logic [10:0] loss_detect_time;
	logic [4:0]  cfg_func;
	logic [10:0] cfg_time;
	logic        wr_guard, wr_relay, wr_out2, wr_crit, wr_act, wr_time;

	assign cfg_func = cfg.data[4:0];
	assign cfg_time = cfg.data[10:0];
	// out-of-range values are ignored, the old setting stays
	assign wr_guard = cfg_wr && cfg.sel == CFG_OPEN_PHASE && cfg.data <= 12'h001;
	assign wr_relay = cfg_wr && cfg.sel == CFG_RELAY_FUNC && cfg.data <= 12'(OUT_FUNC_MAX);
	assign wr_out2  = cfg_wr && cfg.sel == CFG_OUT2_FUNC && cfg.data <= 12'(OUT_FUNC_MAX);
	assign wr_crit  = cfg_wr && cfg.sel == CFG_LOSS_CRIT && cfg.data <= 12'(CRIT_MAX);
	assign wr_act   = cfg_wr && cfg.sel == CFG_LOSS_ACT && cfg.data <= 12'(ACT_MAX);
	assign wr_time  = cfg_wr && cfg.sel == CFG_LOSS_TIME &&
		cfg.data >= 12'(LOSS_TIME_MIN) && cfg.data <= 12'(LOSS_TIME_MAX);

	// scalar settings
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			open_phase_guard_select <= 1'b0;
			relay_function_select   <= OUT_FUNC_RST;
			output2_function_select <= OUT_FUNC_RST;
			loss_criterion_select   <= 2'h0;
			loss_action_select      <= ACT_HOLD;
			loss_detect_time        <= LOSS_TIME_RST;
		end else begin
			if (wr_guard) open_phase_guard_select <= cfg.data[0];
			if (wr_relay) relay_function_select <= cfg_func;
			if (wr_out2)  output2_function_select <= cfg_func;
			if (wr_crit)  loss_criterion_select <= cfg.data[1:0];
			if (wr_act)   loss_action_select <= cfg.data[1:0];
			if (wr_time)  loss_detect_time <= cfg_time;
		end
	end

	// ************************************************************
	// multi-function inputs and external trips
	// ************************************************************
	localparam logic [4:0] IN_RST [NUM_INPUTS] =
		'{IN1_FUNC_RST, IN2_FUNC_RST, IN3_FUNC_RST, IN4_FUNC_RST, IN5_FUNC_RST};
	logic [NUM_INPUTS-1:0] no_hit, nc_hit, nc_ready;
	logic [NUM_INPUTS-1:0] nc_src_r;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
			logic wr_in, avail;
			assign wr_in = cfg_wr && cfg.sel == CFG_IN1_FUNC + 4'(gi) &&
				cfg.data <= 12'(IN_FUNC_MAX);
			assign avail = (gi < STD_INPUTS) || advanced_io;
			// closed contact to common reads as 1
			assign no_hit[gi] = avail && in_func_r[gi] == IN_FUNC_NO_TRIP &&
				input_terminal[gi];
			assign nc_hit[gi] = avail && in_func_r[gi] == IN_FUNC_NC_TRIP &&
				!input_terminal[gi];
			// a source input may release only if still assigned and closed again
			assign nc_ready[gi] = !nc_src_r[gi] ||
				(in_func_r[gi] == IN_FUNC_NC_TRIP && input_terminal[gi]);
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					in_func_r[gi] <= IN_RST[gi];
				else if (wr_in)
					in_func_r[gi] <= cfg_func;
			end
		end
	endgenerate

	// ************************************************************
	// speed command loss qualification
	// ************************************************************
	logic        loss_cond, loss_confirm;
	logic [31:0] loss_div_r;
	logic [10:0] loss_cnt_r;
	logic        loss_tick;

	// either half of a combined reference counts as a loss
	assign loss_cond =
		(speed_ref_source == REF_MAIN_V) ?
			below(main_voltage_input, main_voltage_loss_threshold, loss_criterion_select) :
		(speed_ref_source == REF_ALT_V_AUX_I) ?
			(below(alt_voltage_input, alt_voltage_loss_threshold, loss_criterion_select) ||
			 below(aux_current_input, aux_current_loss_threshold, loss_criterion_select)) :
			1'b0;
	assign loss_tick    = (loss_div_r == 32'(LOSS_TICK - 1));
	assign loss_confirm = loss_cond && loss_cnt_r >= loss_detect_time;

	// counts whole 0.1 s steps of uninterrupted loss
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loss_div_r <= 32'h0;
			loss_cnt_r <= 11'h0;
		end else if (!loss_cond) begin
			loss_div_r <= 32'h0;
			loss_cnt_r <= 11'h0;
		end else begin
			loss_div_r <= loss_tick ? 32'h0 : loss_div_r + 32'h1;
			if (loss_tick && loss_cnt_r != LOSS_TIME_MAX)
				loss_cnt_r <= loss_cnt_r + 11'h1;
		end
	end

	// ************************************************************
	// overload integrator
	// ************************************************************
	logic ol_now;

	dpt_overload #(
		.CUR_W    (CUR_W),
		.TICK_CYC (OL_TICK)
	) u_overload (
		.clk           (clk),
		.reset_n       (reset_n),
		.input_current (input_current),
		.rated_current (inverter_rated_current),
		.overload_r    (ol_now)
	);

	// ************************************************************
	// trip latches and outputs
	// ************************************************************
	logic      op_hit;
	dpt_trip_t hit, gone, trip_nxt;
	logic      block_nxt;

	assign op_hit = open_phase_guard_select && (|phase_open);
	assign hit    = '{open_phase: op_hit, ext_no: |no_hit, ext_nc: |nc_hit,
		overload: ol_now, cmd_loss: loss_confirm};
	assign gone   = '{open_phase: !(|phase_open), ext_no: !(|no_hit),
		ext_nc: &nc_ready, overload: !ol_now, cmd_loss: !loss_cond};
	// a new event wins over a clear in the same cycle
	assign trip_nxt = hit | (trip_status_r & ~(gone & {5{clear_req}}));
	assign block_nxt = trip_nxt.open_phase || trip_nxt.ext_no || trip_nxt.ext_nc ||
		trip_nxt.overload || (trip_nxt.cmd_loss && loss_action_select == ACT_FREE_RUN);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_status_r  <= '0;
			nc_src_r       <= '0;
			output_block_r <= 1'b0;
			decel_stop_r   <= 1'b0;
			hold_speed_r   <= 1'b0;
			trip_relay_r   <= 1'b0;
			output2_r      <= 1'b0;
		end else begin
			trip_status_r  <= trip_nxt;
			nc_src_r       <= trip_nxt.ext_nc ? (nc_src_r | nc_hit) : '0;
			output_block_r <= block_nxt;
			decel_stop_r   <= trip_nxt.cmd_loss && loss_action_select == ACT_DECEL;
			hold_speed_r   <= trip_nxt.cmd_loss && loss_action_select == ACT_HOLD;
			trip_relay_r   <= out_drive(relay_function_select, trip_nxt);
			output2_r      <= out_drive(output2_function_select, trip_nxt);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	AST_OPEN_PHASE_BLOCK: assert property (@(posedge clk) disable iff (!reset_n)
		open_phase_guard_select && (|phase_open) |=> output_block_r && trip_status_r.open_phase)
		else $error("open phase did not block output");
	AST_GUARD_OFF: assert property (@(posedge clk) disable iff (!reset_n)
		!open_phase_guard_select && !trip_status_r.open_phase |=> !trip_status_r.open_phase)
		else $error("open phase trip while guard disabled");
	AST_NO_TRIP: assert property (@(posedge clk) disable iff (!reset_n)
		|no_hit |=> trip_status_r.ext_no && output_block_r)
		else $error("normally-open trip missed");
	AST_NC_TRIP: assert property (@(posedge clk) disable iff (!reset_n)
		|nc_hit |=> trip_status_r.ext_nc && output_block_r)
		else $error("normally-closed trip missed");
	AST_NC_STUCK: assert property (@(posedge clk) disable iff (!reset_n)
		trip_status_r.ext_nc && !(&nc_ready) |=> trip_status_r.ext_nc)
		else $error("reassigned normally-closed trip was cleared");
	AST_STD_INPUTS: assert property (@(posedge clk) disable iff (!reset_n)
		!advanced_io |-> !no_hit[4] && !no_hit[3] && !nc_hit[4] && !nc_hit[3])
		else $error("trip taken on input missing from standard set");
	AST_OL_RELAY: assert property (@(posedge clk) disable iff (!reset_n)
		relay_function_select == OUT_FUNC_OL && $past(relay_function_select) == OUT_FUNC_OL
		&& trip_status_r.overload |-> trip_relay_r)
		else $error("relay not showing overload trip");
	AST_LOSS_RELAY: assert property (@(posedge clk) disable iff (!reset_n)
		output2_function_select == OUT_FUNC_LOSS && $past(output2_function_select)
		== OUT_FUNC_LOSS |-> output2_r == trip_status_r.cmd_loss)
		else $error("output 2 not showing command loss");
	AST_OUT_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
		relay_function_select <= OUT_FUNC_MAX && output2_function_select <= OUT_FUNC_MAX)
		else $error("output function code out of range");
	AST_CRIT_OFF: assert property (@(posedge clk) disable iff (!reset_n)
		loss_criterion_select == 2'h0 |-> !loss_cond)
		else $error("loss seen with detection disabled");
	AST_COMBINED_REF: assert property (@(posedge clk) disable iff (!reset_n)
		speed_ref_source == REF_ALT_V_AUX_I && loss_criterion_select == CRIT_FULL &&
		aux_current_input < aux_current_loss_threshold |-> loss_cond)
		else $error("low current half of reference not seen as loss");
	AST_LOSS_QUALIFY: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(trip_status_r.cmd_loss) |-> $past(loss_cnt_r) >= $past(loss_detect_time))
		else $error("command loss acted on before detect time");
	AST_LOSS_ACTION: assert property (@(posedge clk) disable iff (!reset_n)
		trip_status_r.cmd_loss && loss_action_select == ACT_DECEL &&
		$stable(loss_action_select) |-> decel_stop_r && !hold_speed_r)
		else $error("deceleration stop not issued on loss");
	AST_TRIP_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
		trip_status_r.overload && !clear_req |=> trip_status_r.overload)
		else $error("overload trip dropped without clear");
	AST_NC_CODE: assert property (@(posedge clk) disable iff (!reset_n)
		advanced_io && in_func_r[4] == IN_FUNC_NC_TRIP && !input_terminal[4] |=>
		trip_status_r.ext_nc)
		else $error("input 5 normally-closed code not honoured");

endmodule

//--- dpt_plant.sv
// partner model: motor phases, trip contacts, analog references, load
// assumes bench commands change at the rising edge of clk
`timescale 1ns/1ps
module dpt_plant #(
	parameter logic [11:0] RATED = 12'h100
) (
	input  wire logic        clk,
	input  wire logic [2:0]  phase_fault,
	input  wire logic        no_tripped,
	input  wire logic        nc_tripped,
	input  wire logic [9:0]  ref_v,
	input  wire logic [9:0]  ref_i,
	input  wire logic [11:0] excess,
	output logic [2:0]       phase_open,
	output logic [4:0]       input_terminal,
	output logic [9:0]       main_v,
	output logic [9:0]       alt_v,
	output logic [9:0]       aux_i,
	output logic [11:0]      current
);
	// ****
	// field side, updated just after each rising edge
	// ****
	always_ff @(posedge clk) begin
		phase_open     <= phase_fault;
		input_terminal <= {~nc_tripped, no_tripped, 3'h0}; // closes on trip opens
		main_v         <= ref_v;
		alt_v          <= ref_v;
		aux_i          <= ref_i;
		current        <= RATED + excess;                  // load above rating
	end
endmodule

//--- test_dpt_trip_logic.sv
// self-checking bench of the drive protection trip logic
// assumes dpt_pkg, dpt_trip_logic and dpt_plant are compiled first
`timescale 1ns/1ps
module test_dpt_trip_logic;
	import dpt_pkg::*;
	localparam logic [9:0] THR = 10'h0c8;
	logic       clk, reset_n, cfg_wr, advanced_io, clear_req, no_tripped, nc_tripped;
	dpt_cfg_t   cfg;
	logic [2:0] phase_fault, phase_open;
	logic [4:0] input_terminal;
	logic [1:0] speed_ref_source;
	logic [9:0] ref_v, ref_i, main_v, alt_v, aux_i;
	logic [11:0] excess, current;
	dpt_trip_t  trips;
	logic       block, decel, hold, relay, out2;
	int         failures, cmp_count, cycles, i, t;
	logic [4:0] act_exp [3];
	wire logic [4:0] outs = {block, decel, hold, relay, out2};

	dpt_plant plant (.clk(clk), .phase_fault(phase_fault), .no_tripped(no_tripped),
		.nc_tripped(nc_tripped), .ref_v(ref_v), .ref_i(ref_i), .excess(excess),
		.phase_open(phase_open), .input_terminal(input_terminal), .main_v(main_v),
		.alt_v(alt_v), .aux_i(aux_i), .current(current));

	dpt_trip_logic #(.LOSS_TICK(10), .OL_TICK(4)) dut (.clk(clk), .reset_n(reset_n),
		.cfg_wr(cfg_wr), .cfg(cfg), .advanced_io(advanced_io), .phase_open(phase_open),
		.input_terminal(input_terminal), .input_current(current),
		.inverter_rated_current(12'h100), .speed_ref_source(speed_ref_source),
		.main_voltage_input(main_v), .alt_voltage_input(alt_v), .aux_current_input(aux_i),
		.main_voltage_loss_threshold(THR), .alt_voltage_loss_threshold(THR),
		.aux_current_loss_threshold(THR), .clear_req(clear_req), .trip_status_r(trips),
		.output_block_r(block), .decel_stop_r(decel), .hold_speed_r(hold),
		.trip_relay_r(relay), .output2_r(out2));

	// ****
	// access tasks
	// ****
	task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [3:0] s, input logic [11:0] d);
		@(posedge clk) begin
			cfg_wr <= 1'b1;
			cfg    <= '{sel: s, data: d};
		end
		@(posedge clk) cfg_wr <= 1'b0;
	endtask
	task automatic clr();
		@(posedge clk) clear_req <= 1'b1;
		@(posedge clk) clear_req <= 1'b0;
		step(2);
	endtask
	task automatic do_reset();
		@(posedge clk) reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		step(1);
		chk("reset_outs", 5'h00, outs);
	endtask
	// overload run: time to trip for a given excess over rating
	task automatic ol_run(input logic [11:0] ex, input int ticks);
		@(posedge clk) excess <= ex;
		do_reset();
		wr(CFG_RELAY_FUNC, 12'h006);
		wr(CFG_RELAY_FUNC, 12'h014);
		wr(CFG_OUT2_FUNC, 12'h006);
		t = 0;
		while (trips.overload !== 1'b1 && t < 1000) begin
			step(1);
			t++;
		end
		chk("ol_time", 5'h01, 5'(t > ticks * 4 - 12 && t < ticks * 4 + 6));
		chk("ol_outs", 5'h13, outs);
		$display("test overload excess %0d done", ex);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****
	// clock and hang guard
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	// ****
	// test sequence
	// ****
	initial begin
		{reset_n, cfg_wr, advanced_io, clear_req, no_tripped, nc_tripped} = '0;
		{cfg, phase_fault, speed_ref_source, excess} = '0;
		ref_v = 10'h12c;
		ref_i = 10'h12c;
		act_exp = '{5'h07, 5'h13, 5'h0b};
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		step(1);
		// open phase: guard off by default, bad value refused, then each phase
		@(posedge clk) phase_fault <= 3'h1;
		step(3);
		chk("op_default", 5'h00, trips);
		wr(CFG_OPEN_PHASE, 12'h002);
		step(3);
		chk("op_refused", 5'h00, trips);
		wr(CFG_OPEN_PHASE, 12'h001);
		clr();
		chk("op_held", 5'h10, trips);
		for (i = 0; i < 3; i++) begin
			@(posedge clk) phase_fault <= 3'(1 << i);
			step(3);
			chk("op_outs", 5'h10, outs);
			@(posedge clk) phase_fault <= 3'h0;
			clr();
			chk("op_clear", 5'h00, trips);
		end
		$display("test open phase done");
		// normally-open trip on input 4, out-of-range code refused
		wr(CFG_IN1_FUNC + 4'h3, 12'h012);
		wr(CFG_IN1_FUNC + 4'h3, 12'h01c);
		@(posedge clk) no_tripped <= 1'b1;
		step(3);
		chk("no_std_io", 5'h00, trips);
		@(posedge clk) advanced_io <= 1'b1;
		step(3);
		chk("no_trip", 5'h08, trips);
		chk("no_block", 5'h10, outs);
		@(posedge clk) no_tripped <= 1'b0;
		clr();
		chk("no_clear", 5'h00, trips);
		// normally-closed trip on input 5, reassigned before clearing
		wr(CFG_IN1_FUNC + 4'h4, 12'h013);
		step(3);
		chk("nc_normal", 5'h00, trips);
		@(posedge clk) nc_tripped <= 1'b1;
		step(3);
		chk("nc_trip", 5'h04, trips);
		wr(CFG_IN1_FUNC + 4'h4, 12'h000);
		@(posedge clk) nc_tripped <= 1'b0;
		clr();
		chk("nc_stuck", 5'h04, trips);
		wr(CFG_IN1_FUNC + 4'h4, 12'h013);
		clr();
		chk("nc_clear", 5'h00, outs);
		$display("test external trips done");
		// speed command loss on the main voltage reference, every action
		wr(CFG_RELAY_FUNC, 12'h00b);
		wr(CFG_OUT2_FUNC, 12'h00b);
		wr(CFG_LOSS_TIME, 12'h002);
		wr(CFG_LOSS_TIME, 12'h000);
		wr(CFG_LOSS_CRIT, 12'h001);
		@(posedge clk) speed_ref_source <= REF_MAIN_V;
		@(posedge clk) ref_v <= 10'h096;
		step(30);
		chk("half_ok", 5'h00, trips);
		for (i = 0; i < 3; i++) begin
			wr(CFG_LOSS_ACT, 12'(i));
			@(posedge clk) ref_v <= 10'h032;
			step(18);
			chk("loss_early", 5'h00, trips);
			t = 0;
			while (trips.cmd_loss !== 1'b1 && t < 6) begin
				step(1);
				t++;
			end
			chk("loss_trip", 5'h01, trips);
			chk("loss_outs", act_exp[i], outs);
			@(posedge clk) ref_v <= 10'h12c;
			clr();
			chk("loss_clear", 5'h00, outs);
		end
		// combined reference: current half low under the full criterion
		wr(CFG_LOSS_CRIT, 12'h002);
		@(posedge clk) speed_ref_source <= REF_ALT_V_AUX_I;
		@(posedge clk) ref_i <= 10'h096;
		step(30);
		chk("comb_loss", 5'h01, trips);
		wr(CFG_LOSS_CRIT, 12'h000);
		clr();
		step(30);
		chk("crit_off", 5'h00, trips);
		$display("test command loss done");
		// overload: larger excess trips sooner
		ol_run(12'hc35, 32);
		ol_run(12'h7d0, 50);
		finish_test();
	end
endmodule
